// file: design/cse_bit_if.sv
// Bit handshake from the frame sequencer to the single-wire encoder.
// Both ends run on the system clock.
interface cse_bit_if;
    logic valid;
    logic ready;
    logic bit_val;
    modport src(output valid, output bit_val, input ready);
    modport snk(input valid, input bit_val, output ready);
endinterface : cse_bit_if

// file: design/cse_host.sv
// Host controller for the configuration port: drives the two-wire shift
// clock and data line, the single-wire input and the device reset pin.
// Assumes requests from logic on sys_clk_i; the data line input is a pin.
// Function
// - Register write: start, 00, address, data
// - Address top bit always sent zero
// - Register read: start, 10, address, data returned
// - One idle clock before read data
// - EEPROM frames: start then four command bits
// - EEPROM write: 3-bit address, 32 data bits
// - Wait 20 ms after EEPROM writes
// - EEPROM read: 1100, address, turnaround, 32 bits
// - One extra low-data clock after each two-wire frame
// - Slow clock phases for EEPROM reads
// - Device samples falling, drives after rising
// - Limits scale with device oscillator frequency
// - Fifty low-data clocks resynchronise the port
// - No traffic while device reset asserted
// - Single-wire bit phase lengths per value
// - Single-wire frame: start, command, stop zero
// - Single-wire EEPROM command after start bit
// - Host drives clock; data line shared
module cse_host #(
    parameter int GUARD_CYC = cse_pkg::GUARD_CYC
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    // Request
    input wire logic req_valid_i,
    output logic req_ready_o,
    input wire logic [1:0] req_kind_i,
    input wire logic req_one_wire_i,
    input wire logic [3:0] req_ee_cmd_i,
    input wire logic [4:0] req_addr_i,
    input wire logic [31:0] req_wdata_i,
    input wire logic dev_reset_i,
    // Answer
    output logic resp_valid_o,
    output logic resp_err_o,
    output logic [31:0] resp_rdata_o,
    // Two-wire port pins
    output logic two_wire_sclk_o,
    output logic bidir_serial_line_o,
    output logic bidir_serial_line_oe_o,
    input wire logic bidir_serial_line_i,
    // Single-wire and reset pins
    output logic single_wire_input_o,
    output logic reset_pin_low_active_n_o
);
    localparam int CW = cse_pkg::CNT_W;
    localparam int FW = cse_pkg::FRAME_W;

    cse_pkg::cse_state_t state_reg;
    cse_pkg::cse_state_t state_next;
    logic [FW-1:0] shift_reg;
    logic [FW-1:0] shift_next;
    logic [5:0] bits_reg;
    logic [5:0] bits_next;
    logic [5:0] trail_reg;
    logic [5:0] trail_next;
    logic [5:0] rd_bits_reg;
    logic [5:0] rd_bits_next;
    logic slow_reg;
    logic slow_next;
    logic read_reg;
    logic read_next;
    logic guard_reg;
    logic guard_next;
    logic sclk_reg;
    logic sclk_next;
    logic bidir_serial_line_reg;
    logic bidir_serial_line_next;
    logic oe_reg;
    logic oe_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic resp_reg;
    logic resp_next;
    logic err_reg;
    logic err_next;
    logic rst_pin_reg;
    logic bidir_serial_line_meta_reg;
    logic bidir_serial_line_sync_reg;
    logic tick;

    cse_bit_if ow_if ();

    // Request decode
    wire is_ee = (req_kind_i == cse_pkg::K_EE);
    wire is_rd = (req_kind_i == cse_pkg::K_REG_RD);
    wire is_resync = (req_kind_i == cse_pkg::K_RESYNC);
    wire ee_rd = is_ee && (req_ee_cmd_i == cse_pkg::EE_READ);
    wire ee_wr = is_ee && cse_pkg::ee_is_write(req_ee_cmd_i);
    wire ee_bad = is_ee && (req_ee_cmd_i == cse_pkg::EE_RESERVED);
    wire ow_bad = req_one_wire_i && (is_rd || ee_rd || is_resync);
    wire req_bad = ee_bad || ow_bad;
    wire take = req_valid_i && req_ready_o;

    // Frame images, left aligned, start bit first
    wire [FW-1:0] frame_reg_wr = {1'b1, cse_pkg::REG_WR_CMD, 1'b0, req_addr_i[3:0],
                                  req_wdata_i[7:0], 24'h000000};
    wire [FW-1:0] frame_reg_rd = {1'b1, cse_pkg::REG_RD_CMD, 1'b0, req_addr_i[3:0],
                                  32'h00000000};
    wire [FW-1:0] frame_ee = {1'b1, req_ee_cmd_i, req_addr_i[2:0],
                              req_wdata_i};
    wire [FW-1:0] frame_sel = is_ee ? frame_ee : (is_rd ? frame_reg_rd : frame_reg_wr);
    wire [5:0] ee_len = cse_pkg::ee_has_data(req_ee_cmd_i) ? cse_pkg::EE_WR_BITS
                                                             : cse_pkg::EE_ADDR_BITS;
    wire [5:0] len_sel = is_ee ? ee_len
                               : (is_rd ? cse_pkg::REG_RD_BITS : cse_pkg::REG_WR_BITS);
    wire [5:0] rd_len = ee_rd ? cse_pkg::EE_DATA_BITS : cse_pkg::REG_DATA_BITS;

    // Phase timer load: guard interval or a clock half period
    wire [CW-1:0] half_len = slow_next ? cse_pkg::HALF_SLOW_CYC
                                       : cse_pkg::HALF_FAST_CYC;
    wire [CW-1:0] tick_load = (state_next == cse_pkg::S_GUARD) ? CW'(GUARD_CYC) : half_len;
    wire restart = (state_next != state_reg);

    cse_tick #(
        .W(CW)
    ) u_tick (
        .sys_clk_i(sys_clk_i),
        .arst_n_i(arst_n_i),
        .restart_i(restart),
        .load_i(tick_load),
        .tick_o(tick)
    );

    cse_ow_tx u_ow_tx (
        .sys_clk_i(sys_clk_i),
        .arst_n_i(arst_n_i),
        .bit_if(ow_if.snk),
        .single_wire_input_o(single_wire_input_o)
    );

    assign ow_if.valid = (state_reg == cse_pkg::S_OW);
    assign ow_if.bit_val = shift_reg[FW-1];

    assign req_ready_o = (state_reg == cse_pkg::S_IDLE) && !dev_reset_i
                         && !rst_pin_reg && ow_if.ready;
    assign resp_valid_o = resp_reg;
    assign resp_err_o = err_reg;
    assign resp_rdata_o = rdata_reg;
    assign two_wire_sclk_o = sclk_reg;
    assign bidir_serial_line_o = bidir_serial_line_reg;
    assign bidir_serial_line_oe_o = oe_reg;
    assign reset_pin_low_active_n_o = !rst_pin_reg;

    always_comb begin
        state_next = state_reg;
        shift_next = shift_reg;
        bits_next = bits_reg;
        trail_next = trail_reg;
        rd_bits_next = rd_bits_reg;
        slow_next = slow_reg;
        read_next = read_reg;
        guard_next = guard_reg;
        sclk_next = sclk_reg;
        bidir_serial_line_next = bidir_serial_line_reg;
        oe_next = oe_reg;
        rdata_next = rdata_reg;
        resp_next = 1'b0;
        err_next = err_reg;
        case (state_reg)
            cse_pkg::S_IDLE: begin
                if (take) begin
                    err_next = req_bad;
                    if (req_bad) begin
                        resp_next = 1'b1;
                    end else begin
                        shift_next = frame_sel;
                        bits_next = len_sel;
                        rd_bits_next = rd_len;
                        slow_next = ee_rd;
                        read_next = is_rd || ee_rd;
                        guard_next = ee_wr;
                        rdata_next = 32'h00000000;
                        if (is_resync) begin
                            state_next = cse_pkg::S_TRAIL;
                            trail_next = cse_pkg::RESYNC_CLKS;
                            oe_next = 1'b1;
                            bidir_serial_line_next = 1'b0;
                        end else if (req_one_wire_i) begin
                            state_next = cse_pkg::S_OW;
                            bits_next = len_sel + 6'h01;
                        end else begin
                            state_next = cse_pkg::S_SEND;
                            oe_next = 1'b1;
                        end
                    end
                end
            end
            cse_pkg::S_SEND: begin
                if (tick) begin
                    if (!sclk_reg) begin
                        // Data changes with the rising edge, steady across the falling one
                        sclk_next = 1'b1;
                        bidir_serial_line_next = shift_reg[FW-1];
                        shift_next = {shift_reg[FW-2:0], 1'b0};
                    end else begin
                        sclk_next = 1'b0;
                        bits_next = bits_reg - 6'h01;
                        if (bits_reg == 6'h01) begin
                            state_next = read_reg ? cse_pkg::S_TURN : cse_pkg::S_TRAIL;
                            trail_next = cse_pkg::TRAIL_CLKS;
                        end
                    end
                end
            end
            cse_pkg::S_TURN: begin
                if (tick) begin
                    if (!sclk_reg) begin
                        sclk_next = 1'b1;
                        oe_next = 1'b0;
                    end else begin
                        sclk_next = 1'b0;
                        state_next = cse_pkg::S_RECV;
                        bits_next = rd_bits_reg;
                    end
                end
            end
            cse_pkg::S_RECV: begin
                if (tick) begin
                    if (!sclk_reg) begin
                        sclk_next = 1'b1;
                    end else begin
                        // Capture at the end of the high phase, before the falling edge
                        sclk_next = 1'b0;
                        rdata_next = {rdata_reg[30:0], bidir_serial_line_sync_reg};
                        bits_next = bits_reg - 6'h01;
                        if (bits_reg == 6'h01) begin
                            state_next = cse_pkg::S_TRAIL;
                            trail_next = cse_pkg::TRAIL_CLKS;
                        end
                    end
                end
            end
            cse_pkg::S_TRAIL: begin
                if (tick) begin
                    if (!sclk_reg) begin
                        sclk_next = 1'b1;
                        oe_next = 1'b1;
                        bidir_serial_line_next = 1'b0;
                    end else begin
                        sclk_next = 1'b0;
                        trail_next = trail_reg - 6'h01;
                        if (trail_reg == 6'h01) begin
                            state_next = guard_reg ? cse_pkg::S_GUARD : cse_pkg::S_IDLE;
                            resp_next = !guard_reg;
                        end
                    end
                end
            end
            cse_pkg::S_GUARD: begin
                if (tick) begin
                    state_next = cse_pkg::S_IDLE;
                    resp_next = 1'b1;
                end
            end
            cse_pkg::S_OW: begin
                if (ow_if.ready) begin
                    shift_next = {shift_reg[FW-2:0], 1'b0};
                    bits_next = bits_reg - 6'h01;
                    if (bits_reg == 6'h01) begin
                        state_next = cse_pkg::S_OW_END;
                    end
                end
            end
            cse_pkg::S_OW_END: begin
                if (ow_if.ready) begin
                    state_next = guard_reg ? cse_pkg::S_GUARD : cse_pkg::S_IDLE;
                    resp_next = !guard_reg;
                end
            end
            default: begin
                state_next = cse_pkg::S_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_reg <= cse_pkg::S_IDLE;
            shift_reg <= '0;
            bits_reg <= 6'h00;
            trail_reg <= 6'h00;
            rd_bits_reg <= 6'h00;
            slow_reg <= 1'b0;
            read_reg <= 1'b0;
            guard_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            shift_reg <= shift_next;
            bits_reg <= bits_next;
            trail_reg <= trail_next;
            rd_bits_reg <= rd_bits_next;
            slow_reg <= slow_next;
            read_reg <= read_next;
            guard_reg <= guard_next;
        end
    end

    // Pin and answer registers
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sclk_reg <= 1'b0;
            bidir_serial_line_reg <= 1'b0;
            oe_reg <= 1'b1;
            rdata_reg <= 32'h00000000;
            resp_reg <= 1'b0;
            err_reg <= 1'b0;
            rst_pin_reg <= 1'b1;
        end else begin
            sclk_reg <= sclk_next;
            bidir_serial_line_reg <= bidir_serial_line_next;
            oe_reg <= oe_next;
            rdata_reg <= rdata_next;
            resp_reg <= resp_next;
            err_reg <= err_next;
            rst_pin_reg <= dev_reset_i && (state_reg == cse_pkg::S_IDLE);
        end
    end

    // Data line input crosses from the pin
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            bidir_serial_line_meta_reg <= 1'b0;
            bidir_serial_line_sync_reg <= 1'b0;
        end else begin
            bidir_serial_line_meta_reg <= bidir_serial_line_i;
            bidir_serial_line_sync_reg <= bidir_serial_line_meta_reg;
        end
    end
endmodule : cse_host

// file: design/cse_ow_tx.sv
// Single-wire pulse-width encoder: each bit is a low phase then a high phase.
// Assumes one bit offered at a time on the handshake; the wire rests high.
module cse_ow_tx (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    // Bits to send
    cse_bit_if.snk bit_if,
    // Wire to the device
    output logic single_wire_input_o
);
    localparam int CW = cse_pkg::OW_CNT_W;

    cse_pkg::cse_ow_state_t state_reg;
    cse_pkg::cse_ow_state_t state_next;
    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;
    logic val_reg;
    logic val_next;
    logic line_reg;
    logic line_next;

    wire cnt_done = (cnt_reg == '0);
    wire [CW-1:0] low_len = bit_if.bit_val ? cse_pkg::OW_LONG_CYC : cse_pkg::OW_SHORT_CYC;
    wire [CW-1:0] high_len = val_reg ? cse_pkg::OW_SHORT_CYC : cse_pkg::OW_LONG_CYC;

    assign bit_if.ready = (state_reg == cse_pkg::OW_IDLE);
    assign single_wire_input_o = line_reg;

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_done ? cnt_reg : cnt_reg - CW'(1);
        val_next = val_reg;
        line_next = line_reg;
        case (state_reg)
            cse_pkg::OW_IDLE: begin
                line_next = 1'b1;
                if (bit_if.valid) begin
                    state_next = cse_pkg::OW_LOW;
                    val_next = bit_if.bit_val;
                    cnt_next = low_len - CW'(1);
                    line_next = 1'b0;
                end
            end
            cse_pkg::OW_LOW: begin
                if (cnt_done) begin
                    state_next = cse_pkg::OW_HIGH;
                    cnt_next = high_len - CW'(1);
                    line_next = 1'b1;
                end
            end
            cse_pkg::OW_HIGH: begin
                if (cnt_done) begin
                    state_next = cse_pkg::OW_IDLE;
                end
            end
            default: begin
                state_next = cse_pkg::OW_IDLE;
                line_next = 1'b1;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_reg <= cse_pkg::OW_IDLE;
            cnt_reg <= '0;
            val_reg <= 1'b0;
            line_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            val_reg <= val_next;
            line_reg <= line_next;
        end
    end
endmodule : cse_ow_tx

// file: design/cse_pkg.sv
// Shared constants, enumerations and decode helpers of the configuration port host.
// Assumes a single 25 MHz system clock; all pin timing is derived here.
package cse_pkg;

    // System clock and the device oscillator assumed for timing limits
    localparam int CLK_MHZ = 25;
    localparam int OSC_REF_KHZ = 20000;
    localparam int OSC_MIN_KHZ = 20000;
    localparam int CNT_W = 20;

    // Two-wire shift clock phases, scaled to the slowest device oscillator
    localparam int HALF_FAST_NS = 400;
    localparam int HALF_SLOW_NS = 8000;
    localparam logic [CNT_W-1:0] HALF_FAST_CYC = CNT_W'(
        (HALF_FAST_NS * (OSC_REF_KHZ / 1000) * CLK_MHZ + (OSC_MIN_KHZ / 1000) * 1000 - 1)
        / ((OSC_MIN_KHZ / 1000) * 1000));
    localparam logic [CNT_W-1:0] HALF_SLOW_CYC = CNT_W'(
        (HALF_SLOW_NS * (OSC_REF_KHZ / 1000) * CLK_MHZ + (OSC_MIN_KHZ / 1000) * 1000 - 1)
        / ((OSC_MIN_KHZ / 1000) * 1000));

    // Quiet time after an EEPROM write, in milliseconds and cycles
    localparam int GUARD_MS = 20;
    localparam int GUARD_CYC = GUARD_MS * 1000 * CLK_MHZ;

    // Trailing low clocks after a frame, and after a resynchronisation
    localparam logic [5:0] TRAIL_CLKS = 6'h01;
    localparam logic [5:0] RESYNC_CLKS = 6'h32;

    // Single-wire bit phases: centre of each documented window
    localparam int OW_SHORT_MIN_US = 40;
    localparam int OW_SHORT_MAX_US = 100;
    localparam int OW_LONG_MIN_US = 120;
    localparam int OW_LONG_MAX_US = 200;
    localparam int OW_CNT_W = 13;
    localparam logic [OW_CNT_W-1:0] OW_SHORT_CYC =
        OW_CNT_W'((OW_SHORT_MIN_US + OW_SHORT_MAX_US) / 2 * CLK_MHZ);
    localparam logic [OW_CNT_W-1:0] OW_LONG_CYC =
        OW_CNT_W'((OW_LONG_MIN_US + OW_LONG_MAX_US) / 2 * CLK_MHZ);

    // Frame layout
    localparam int FRAME_W = 40;
    localparam logic [1:0] REG_WR_CMD = 2'h0;
    localparam logic [1:0] REG_RD_CMD = 2'h2;
    localparam logic [5:0] REG_WR_BITS = 6'h10;
    localparam logic [5:0] REG_RD_BITS = 6'h08;
    localparam logic [5:0] REG_DATA_BITS = 6'h08;
    localparam logic [5:0] EE_WR_BITS = 6'h28;
    localparam logic [5:0] EE_ADDR_BITS = 6'h08;
    localparam logic [5:0] EE_DATA_BITS = 6'h20;

    // EEPROM commands
    localparam logic [3:0] EE_ERASE_WRITE = 4'h4;
    localparam logic [3:0] EE_BLK_ERASE_WRITE = 4'h5;
    localparam logic [3:0] EE_WRITE = 4'h6;
    localparam logic [3:0] EE_BLK_WRITE = 4'h7;
    localparam logic [3:0] EE_READ = 4'hC;
    localparam logic [3:0] EE_RESERVED = 4'hD;
    localparam logic [3:0] EE_ERASE = 4'hE;
    localparam logic [3:0] EE_BLK_ERASE = 4'hF;

    typedef enum logic [1:0] {
        K_REG_WR = 2'h0,
        K_REG_RD = 2'h1,
        K_EE = 2'h2,
        K_RESYNC = 2'h3
    } cse_kind_t;

    typedef enum logic [2:0] {
        S_IDLE = 3'h0,
        S_SEND = 3'h1,
        S_TURN = 3'h2,
        S_RECV = 3'h3,
        S_TRAIL = 3'h4,
        S_GUARD = 3'h5,
        S_OW = 3'h6,
        S_OW_END = 3'h7
    } cse_state_t;

    typedef enum logic [1:0] {
        OW_IDLE = 2'h0,
        OW_LOW = 2'h1,
        OW_HIGH = 2'h2
    } cse_ow_state_t;

    // Commands that alter the EEPROM and so need the quiet time
    function automatic logic ee_is_write(input logic [3:0] cmd);
        ee_is_write = (cmd == EE_ERASE_WRITE) || (cmd == EE_BLK_ERASE_WRITE) ||
                      (cmd == EE_WRITE) || (cmd == EE_BLK_WRITE) ||
                      (cmd == EE_ERASE) || (cmd == EE_BLK_ERASE);
    endfunction : ee_is_write

    // Commands that carry a 32-bit data word
    function automatic logic ee_has_data(input logic [3:0] cmd);
        ee_has_data = (cmd == EE_ERASE_WRITE) || (cmd == EE_BLK_ERASE_WRITE) ||
                      (cmd == EE_WRITE) || (cmd == EE_BLK_WRITE);
    endfunction : ee_has_data

endpackage : cse_pkg

// file: design/cse_tick.sv
// Reloading down-counter that gives a one-cycle enable every load_i cycles.
// Assumes load_i is at least one; restart_i begins a fresh interval.
module cse_tick #(
    parameter int W = 20
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    // Control
    input wire logic restart_i,
    input wire logic [W-1:0] load_i,
    // Enable pulse
    output logic tick_o
);
    logic [W-1:0] cnt_reg;
    logic [W-1:0] cnt_next;
    wire reload = restart_i || (cnt_reg == '0);

    assign tick_o = (cnt_reg == '0);
    assign cnt_next = reload ? load_i - W'(1) : cnt_reg - W'(1);

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end
endmodule : cse_tick

// file: testbench/cse_dev_model.sv
// Behavioural device: register bank and EEPROM behind the two-wire port.
// Assumes the bench resolves the shared data line from both enables.
module cse_dev_model (
    // Two-wire pins
    input wire logic sclk_i,
    input wire logic line_i,
    // Data line drive
    output logic oe_o,
    output logic d_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] regs [16];
    logic [31:0] ee [8];
    logic [31:0] v;
    logic [3:0] c;
    logic [2:0] a;
    // Shift n bits in at falling clock edges
    task automatic get(input int n);
        v = 32'h0;
        repeat (n) begin
            @(negedge sclk_i);
            v = {v[30:0], line_i};
        end
    endtask : get
    // Idle clock, then drive n bits after rising edges, then release
    task automatic put(input int n, input logic [31:0] w);
        @(negedge sclk_i);
        for (int i = n - 1; i >= 0; i--) begin
            @(posedge sclk_i);
            #5;
            oe_o = 1'b1;
            d_o = w[i];
        end
        @(posedge sclk_i);
        #5 oe_o = 1'b0;
    endtask : put
    initial begin
        oe_o = 1'b0;
        d_o = 1'b0;
        forever begin
            get(1);
            // Low bits between frames keep the port idle
            if (v[0]) begin
                get(2);
                c[3:2] = v[1:0];
                if (c[3:2] == 2'h0) begin
                    get(5);
                    a = {2'h0, v[4]};
                    c = v[3:0];
                    get(8);
                    if (a == 3'h0) regs[c] = v[7:0];
                end else if (c[3:2] == 2'h2) begin
                    get(5);
                    put(8, {24'h0, regs[v[3:0]]});
                end else begin
                    get(5);
                    c[1:0] = v[4:3];
                    a = v[2:0];
                    if (c == 4'hC) begin
                        put(32, ee[a]);
                    end else if (c[3:2] == 2'h1) begin
                        get(32);
                        ee[a] = v;
                    end
                end
            end
        end
    end
endmodule : cse_dev_model

// file: testbench/cse_host_asserts.sv
// Pin-level checker for the configuration port host.
// Sees only the top module ports; bound to every cse_host instance.
module cse_host_asserts (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    // Request side
    input wire logic req_valid_i,
    input wire logic req_ready_o,
    input wire logic [1:0] req_kind_i,
    input wire logic req_one_wire_i,
    input wire logic [3:0] req_ee_cmd_i,
    input wire logic resp_valid_o,
    input wire logic resp_err_o,
    // Pins
    input wire logic two_wire_sclk_o,
    input wire logic bidir_serial_line_o,
    input wire logic bidir_serial_line_oe_o,
    input wire logic single_wire_input_o,
    input wire logic reset_pin_low_active_n_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!arst_n_i);
    wire take = req_valid_i && req_ready_o;
    idle_pins_a: assert property (req_ready_o |-> !two_wire_sclk_o && single_wire_input_o)
        else $error("pins not idle while ready");
    reserved_refused_a: assert property (take && req_kind_i == 2'h2 && !req_one_wire_i
        && req_ee_cmd_i == 4'hD |=> resp_valid_o && resp_err_o) else $error("reserved not refused");
    ow_read_refused_a: assert property (take && req_one_wire_i && req_kind_i == 2'h1
        |=> resp_valid_o && resp_err_o) else $error("single wire read not refused");
    release_on_rise_a: assert property ($fell(bidir_serial_line_oe_o) |-> $rose(two_wire_sclk_o))
        else $error("line released off the rising edge");
    release_held_a: assert property ($fell(bidir_serial_line_oe_o) |-> !bidir_serial_line_oe_o[*8])
        else $error("line taken back during turnaround");
    data_held_a: assert property ($fell(two_wire_sclk_o) && bidir_serial_line_oe_o
        |-> $stable(bidir_serial_line_o)) else $error("data moved at falling edge");
    high_phase_a: assert property ($rose(two_wire_sclk_o) |-> two_wire_sclk_o[*8])
        else $error("clock high phase short");
    low_phase_a: assert property ($fell(two_wire_sclk_o) |-> !two_wire_sclk_o[*8])
        else $error("clock low phase short");
    reset_quiet_a: assert property (!reset_pin_low_active_n_o |-> !two_wire_sclk_o && !req_ready_o)
        else $error("traffic while device in reset");
endmodule : cse_host_asserts
bind cse_host cse_host_asserts u_chk (.*);

// file: testbench/tb.sv
// Self-checking bench: host controller against a behavioural device.
// Assumes cse_dev_model on the two-wire pins; single wire only refused.
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic valid = 1'b0, ow = 1'b0, dev_rst = 1'b0, last = 1'b0;
    logic [1:0] kind = 2'h0;
    logic [3:0] cmd = 4'h0;
    logic [4:0] addr = 5'h00;
    logic [31:0] wd = 32'h0;
    wire ready, rv, rerr, sclk, hd, hoe, sw, rpin, dev_oe, dev_d;
    wire [31:0] rdata;
    // Undriven line shows a changing level
    wire line = hoe ? hd : dev_oe ? dev_d : ~last;
    int n_fail = 0, checks = 0, cyc = 0;
    logic [7:0] reg_m [16];
    logic [31:0] ee_m [8];
    cse_host #(.GUARD_CYC(50)) DUT (.sys_clk_i(clk), .arst_n_i(rst_n), .req_valid_i(valid),
        .req_ready_o(ready), .req_kind_i(kind), .req_one_wire_i(ow), .req_ee_cmd_i(cmd),
        .req_addr_i(addr), .req_wdata_i(wd), .dev_reset_i(dev_rst), .resp_valid_o(rv),
        .resp_err_o(rerr), .resp_rdata_o(rdata), .two_wire_sclk_o(sclk),
        .bidir_serial_line_o(hd), .bidir_serial_line_oe_o(hoe), .bidir_serial_line_i(line),
        .single_wire_input_o(sw), .reset_pin_low_active_n_o(rpin));
    cse_dev_model u_dev (.sclk_i(sclk), .line_i(line), .oe_o(dev_oe), .d_o(dev_d));
    initial forever #20 clk = ~clk;
    task automatic end_sim();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_sim
    always @(posedge clk) begin
        last <= line;
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            n_fail++;
            end_sim();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic req(input logic [1:0] k, input logic w, input logic [3:0] c,
        input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        {kind, ow, cmd, addr, wd} = {k, w, c, a, d};
        valid = 1'b1;
        while (ready !== 1'b1) begin
            @(posedge clk);
            #1;
        end
        @(posedge clk);
        #1 valid = 1'b0;
        while (rv !== 1'b1 && n < 30000) begin
            @(posedge clk);
            #1 n++;
        end
        chk("resp_valid", 32'h1, rv);
    endtask : req
    initial begin
        int s;
        s = $urandom(32'h796B5AFD);
        repeat (5) @(posedge clk);
        #1 rst_n = 1'b1;
        for (int i = 0; i < 16; i++) begin
            reg_m[i] = 8'($urandom);
            req(2'h0, 1'b0, 4'h0, {1'($urandom), 4'(i)}, {24'h0, reg_m[i]});
        end
        for (int i = 15; i >= 0; i -= 3) begin
            req(2'h1, 1'b0, 4'h0, 5'(i), 32'h0);
            chk("reg read", {24'h0, reg_m[i]}, rdata);
        end
        $display("register test done");
        for (int c = 4; c < 8; c++) begin
            ee_m[c] = $urandom;
            req(2'h2, 1'b0, 4'(c), 5'(c), ee_m[c]);
            chk("ee write err", 32'h0, rerr);
        end
        for (int c = 4; c < 8; c += 3) begin
            req(2'h2, 1'b0, 4'hC, 5'(c), 32'h0);
            chk("ee read", ee_m[c], rdata);
        end
        req(2'h2, 1'b0, 4'hE, 5'h05, 32'h0);
        chk("erase err", 32'h0, rerr);
        $display("eeprom test done");
        req(2'h2, 1'b0, 4'hD, 5'h00, 32'h0);
        chk("reserved err", 32'h1, rerr);
        req(2'h1, 1'b1, 4'h0, 5'h01, 32'h0);
        chk("one wire read err", 32'h1, rerr);
        req(2'h3, 1'b0, 4'h0, 5'h00, 32'h0);
        req(2'h1, 1'b0, 4'h0, 5'h02, 32'h0);
        chk("read after resync", {24'h0, reg_m[2]}, rdata);
        $display("refusal test done");
        dev_rst = 1'b1;
        repeat (3) @(posedge clk);
        #1 chk("reset pin", 32'h0, rpin);
        chk("ready in reset", 32'h0, ready);
        chk("single wire idle", 32'h1, sw);
        dev_rst = 1'b0;
        $display("reset test done");
        end_sim();
    end
endmodule : tb
